/* hw/opfc_top.sv */
// Amplifier enable, pin analog select, channel select and port 2 direction over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "opfc_cfg.svh"

module opfc_top #(
    parameter int ADR_W = 18
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] portLatch,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] digitalIn,
    output logic [7:0] analogConnect,
    output logic [7:0] ampConnect,
    output logic [7:0] convertSelect,
    output logic amp0Enable,
    output logic amp1Enable
);

    // Control registers.
    logic [`OPFC_CHAN_W-1:0] chanSel;
    logic [7:0] port2Dir;
    logic [7:0] anaSel;

    // Bus slave state.
    opfc_pkg::opfc_bus_state_t busState;
    opfc_pkg::opfc_bus_state_t next_busState;
    logic [ADR_W-3:0] wordIdx;
    logic busReq;
    logic writeNow;
    logic readNow;
    logic [31:0] next_rdata;

    // Pin input synchroniser; only pinSync may be read by logic.
    logic [7:0] pinMeta;
    logic [7:0] pinSync;

    // Per pin decode results, combinational and registered.
    opfc_pkg::opfc_pin_func_t pinFunc [8];
    opfc_pkg::opfc_pin_func_t funcQ [8];
    logic [7:0] pinConvert;
    logic [7:0] chanHit;
    logic chanOk;
    logic chanOkQ;

    // True when the word address names the given register index.
    function automatic logic hitIdx(input logic [15:0] idx);
        hitIdx = (wordIdx == idx[ADR_W-3:0]);
    endfunction : hitIdx

    // True when a channel code exists on this variant.
    function automatic logic chanValid(input logic [`OPFC_CHAN_W-1:0] code);
        logic [7:0] mask;
        mask = `OPFC_CHAN_VALID_MASK;
        chanValid = mask[code];
    endfunction : chanValid

    assign wordIdx = wb_adr_i[ADR_W-1:2];
    assign busReq = wb_cyc_i && wb_stb_i;

    // The register change lands on the same edge that raises ack, so the
    // master, which samples ack one edge later, always sees the new value.
    always_comb begin
        writeNow = 1'b0;
        readNow = 1'b0;
        if (clkEn && busReq) begin
            if (busState == opfc_pkg::BUS_WAIT) begin
                writeNow = wb_we_i;
            end else if (busState == opfc_pkg::BUS_IDLE) begin
                // A selector write first goes through the wait state.
                writeNow = wb_we_i && !hitIdx(`OPFC_IDX_ANA);
                readNow = !wb_we_i;
            end
        end
    end

    // Next state of the bus slave.
    always_comb begin
        next_busState = busState;
        unique case (busState)
            opfc_pkg::BUS_IDLE: begin
                if (busReq && wb_we_i && hitIdx(`OPFC_IDX_ANA) && wb_sel_i[0]) begin
                    next_busState = opfc_pkg::BUS_WAIT;
                end else if (busReq) begin
                    next_busState = opfc_pkg::BUS_ACK;
                end
            end
            opfc_pkg::BUS_WAIT: begin
                next_busState = opfc_pkg::BUS_ACK;
            end
            opfc_pkg::BUS_ACK: begin
                // Ack is dropped for one cycle so a held request is not taken twice.
                next_busState = opfc_pkg::BUS_IDLE;
            end
        endcase
    end

    // Bus state register; the ack has its own flop, loaded from the decoded next state.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busState <= opfc_pkg::BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else if (clkEn) begin
            busState <= next_busState;
            wb_ack_o <= (next_busState == opfc_pkg::BUS_ACK);
        end
    end

    // Read data mux; unmapped words read as zero and swallow writes.
    always_comb begin
        next_rdata = 32'h00000000;
        if (hitIdx(`OPFC_IDX_AMP)) begin
            // Only the two enable bits exist; the rest read as zero.
            next_rdata[`OPFC_AMP0_BIT] = amp0Enable;
            next_rdata[`OPFC_AMP1_BIT] = amp1Enable;
        end else if (hitIdx(`OPFC_IDX_CHAN)) begin
            next_rdata[`OPFC_CHAN_W-1:0] = chanSel;
        end else if (hitIdx(`OPFC_IDX_DIR)) begin
            next_rdata[7:0] = port2Dir;
        end else if (hitIdx(`OPFC_IDX_ANA)) begin
            next_rdata[7:0] = anaSel;
        end else if (hitIdx(`OPFC_IDX_STAT)) begin
            for (int i = 0; i < 8; i++) begin
                next_rdata[i*`OPFC_STAT_FUNC_W +: `OPFC_STAT_FUNC_W] = funcQ[i];
            end
            next_rdata[`OPFC_STAT_VALID_BIT] = chanOkQ;
        end
    end

    // Read data is captured with the ack and held until the next read.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h00000000;
        end else if (readNow) begin
            wb_dat_o <= next_rdata;
        end
    end

    // Amplifier enables; the flops drive the amplifier bias directly.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            amp0Enable <= `OPFC_RST_AMP;
            amp1Enable <= `OPFC_RST_AMP;
        end else if (writeNow && wb_sel_i[0] && hitIdx(`OPFC_IDX_AMP)) begin
            amp0Enable <= wb_dat_i[`OPFC_AMP0_BIT];
            amp1Enable <= wb_dat_i[`OPFC_AMP1_BIT];
        end
    end

    // Channel select; bits above the field are not stored.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chanSel <= `OPFC_RST_CHAN;
        end else if (writeNow && wb_sel_i[0] && hitIdx(`OPFC_IDX_CHAN)) begin
            chanSel <= wb_dat_i[`OPFC_CHAN_W-1:0];
        end
    end

    // Port 2 direction; a one turns the output buffer off.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port2Dir <= `OPFC_RST_DIR;
        end else if (writeNow && wb_sel_i[0] && hitIdx(`OPFC_IDX_DIR)) begin
            port2Dir <= wb_dat_i[7:0];
        end
    end

    // Analog or digital selector, written only from the wait state.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            anaSel <= `OPFC_RST_ANA;
        end else if (writeNow && wb_sel_i[0] && hitIdx(`OPFC_IDX_ANA)) begin
            anaSel <= wb_dat_i[7:0];
        end
    end

    // Two flop synchroniser on the pad inputs.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
        end else if (clkEn) begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // Channel validity; an unassigned code names no pin at all.
    assign chanOk = chanValid(chanSel);

    // Per pin decode and registered pin controls.
    for (genvar n = 0; n < 8; n++) begin : gPin
        localparam logic [7:0] AMP_IN = `OPFC_AMP_IN_MASK;
        localparam logic [7:0] AMP_OUT = `OPFC_AMP_OUT_MASK;
        localparam logic [7:0] AMP1 = `OPFC_AMP1_MASK;

        assign chanHit[n] = chanOk && (chanSel == n[`OPFC_CHAN_W-1:0]);

        opfc_pin_decode uDecode (
            .analogSel(anaSel[n]),
            .inputMode(port2Dir[n]),
            .ampEnable(AMP1[n] ? amp1Enable : amp0Enable),
            .isAmpIn(AMP_IN[n]),
            .isAmpOut(AMP_OUT[n]),
            .channelHit(chanHit[n]),
            .func(pinFunc[n]),
            .convert(pinConvert[n])
        );

        // Outputs are registered so the pad sees no decode glitches.
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                funcQ[n] <= opfc_pkg::FUNC_DIG_IN;
                pinOe[n] <= 1'b0;
                pinOut[n] <= 1'b0;
                digitalIn[n] <= 1'b0;
                analogConnect[n] <= 1'b0;
                ampConnect[n] <= 1'b0;
                convertSelect[n] <= 1'b0;
            end else if (clkEn) begin
                funcQ[n] <= pinFunc[n];
                // The latch only reaches a pin that is a digital output.
                pinOe[n] <= (pinFunc[n] == opfc_pkg::FUNC_DIG_OUT);
                pinOut[n] <= (pinFunc[n] == opfc_pkg::FUNC_DIG_OUT) && portLatch[n];
                digitalIn[n] <= (pinFunc[n] == opfc_pkg::FUNC_DIG_IN) && pinSync[n];
                analogConnect[n] <= (pinFunc[n] == opfc_pkg::FUNC_ANA_IN)
                    || (pinFunc[n] == opfc_pkg::FUNC_AMP_IN)
                    || (pinFunc[n] == opfc_pkg::FUNC_AMP_OUT);
                ampConnect[n] <= (pinFunc[n] == opfc_pkg::FUNC_AMP_IN)
                    || (pinFunc[n] == opfc_pkg::FUNC_AMP_OUT);
                convertSelect[n] <= pinConvert[n];
            end
        end
    end

    // Registered channel validity for the status word.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chanOkQ <= 1'b1;
        end else if (clkEn) begin
            chanOkQ <= chanOk;
        end
    end

    // Checks on the block's outputs and control registers.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // A taken write to the amplifier register.
    sequence ampWrite;
        writeNow && wb_sel_i[0] && hitIdx(`OPFC_IDX_AMP);
    endsequence

    // A fresh selector write request.
    sequence selWriteReq;
        clkEn && busState == opfc_pkg::BUS_IDLE && busReq && wb_we_i
            && wb_sel_i[0] && hitIdx(`OPFC_IDX_ANA);
    endsequence

    amp0_write_a: assert property (ampWrite |=> amp0Enable == $past(wb_dat_i[7]))
        else $error("amplifier 0 enable did not follow the write");
    amp1_write_a: assert property (ampWrite |=> amp1Enable == $past(wb_dat_i[3]))
        else $error("amplifier 1 enable did not follow the write");
    amp_read_zero_a: assert property (readNow && hitIdx(`OPFC_IDX_AMP)
        |=> wb_ack_o && (wb_dat_o & ~32'h00000088) == 32'h00000000)
        else $error("amplifier register unused bits not zero");
    amp_reset_a: assert property (!$past(rst_n) |-> !amp0Enable && !amp1Enable)
        else $error("amplifier enables not cleared by reset");
    sel_reset_a: assert property (!$past(rst_n) |-> anaSel == 8'h00)
        else $error("selector not cleared by reset");
    sel_wait_a: assert property (selWriteReq ##1 clkEn |-> !wb_ack_o ##1 wb_ack_o)
        else $error("selector write did not take one wait cycle");
    chan1_amp_a: assert property (clkEn && anaSel[1] && port2Dir[1] && amp0Enable
        && chanSel == 3'h1 |=> convertSelect[1] && ampConnect[1])
        else $error("channel 1 amplifier output not converted");
    chan_valid_a: assert property ($onehot0(convertSelect)
        && convertSelect[3] == 1'b0 && convertSelect[4] == 1'b0)
        else $error("unassigned channel or several channels converted");
    chan_reset_a: assert property (!$past(rst_n) |-> chanSel == 3'h0)
        else $error("channel select not cleared by reset");
    latch_ignored_a: assert property ((pinOe & ampConnect) == 8'h00
        && (pinOut & ampConnect) == 8'h00)
        else $error("output latch reached an amplifier pin");
    out_mode_a: assert property (clkEn |=> (ampConnect & ~$past(port2Dir)) == 8'h00)
        else $error("output mode pin serves an amplifier");
    dir_reset_a: assert property (!$past(rst_n) |-> port2Dir == 8'hFF)
        else $error("direction register not set by reset");
    ana_only_a: assert property (clkEn && anaSel[3] && port2Dir[3]
        |=> analogConnect[3] && !ampConnect[3] && !convertSelect[3])
        else $error("plain analog pin misrouted");
    amp_in_a: assert property (clkEn && anaSel[5] && port2Dir[5] && amp1Enable
        && chanSel == 3'h5 |=> ampConnect[5] && convertSelect[5])
        else $error("amplifier input pin not fed and converted");

endmodule : opfc_top

`default_nettype wire

/* hw/opfc_cfg.svh */
// Register indices, field positions, reset values and timing counts for the pin function block.
`ifndef OPFC_CFG_SVH
`define OPFC_CFG_SVH

// Register indices; the Wishbone byte address is four times the index.
`define OPFC_IDX_CHAN 16'hFF0E
`define OPFC_IDX_DIR 16'hFF22
`define OPFC_IDX_AMP 16'hFF60
`define OPFC_IDX_ANA 16'hFF30
`define OPFC_IDX_STAT 16'hFF31

// Reset values.
`define OPFC_RST_CHAN 3'h0
`define OPFC_RST_DIR 8'hFF
`define OPFC_RST_ANA 8'h00
`define OPFC_RST_AMP 1'h0

// Amplifier enable bit positions.
`define OPFC_AMP0_BIT 7
`define OPFC_AMP1_BIT 3

// Channel select field width.
`define OPFC_CHAN_W 3

// Pin roles: amplifier inputs, amplifier outputs, and which pins belong to amplifier 1.
`define OPFC_AMP_IN_MASK 8'hA5
`define OPFC_AMP_OUT_MASK 8'h42
`define OPFC_AMP1_MASK 8'hE0

// Channel codes that exist on the six channel variant.
`define OPFC_CHAN_VALID_MASK 8'hE7

// Extra bus cycles inserted on a selector write.
`define OPFC_SEL_WAIT 1

// Status word layout.
`define OPFC_STAT_FUNC_W 3
`define OPFC_STAT_VALID_BIT 24

`endif

/* hw/opfc_pkg.sv */
// Types shared by the pin function block.
package opfc_pkg;

    // Function that a port 2 pin currently performs.
    typedef enum logic [2:0] {
        FUNC_DIG_IN,
        FUNC_DIG_OUT,
        FUNC_ANA_IN,
        FUNC_AMP_IN,
        FUNC_AMP_OUT,
        FUNC_PROHIBITED
    } opfc_pin_func_t;

    // Wishbone slave states.
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_ACK
    } opfc_bus_state_t;

endpackage : opfc_pkg

/* hw/opfc_pin_decode.sv */
// Combinational decode of one port 2 pin's function from the four control registers.
`timescale 1ns/1ps
`default_nettype none

module opfc_pin_decode (
    input wire logic analogSel,
    input wire logic inputMode,
    input wire logic ampEnable,
    input wire logic isAmpIn,
    input wire logic isAmpOut,
    input wire logic channelHit,
    output opfc_pkg::opfc_pin_func_t func,
    output logic convert
);

    // Prohibited combinations are flagged, not trapped; the pin is then left idle.
    always_comb begin
        func = opfc_pkg::FUNC_PROHIBITED;
        if (analogSel) begin
            if (!inputMode) begin
                func = opfc_pkg::FUNC_PROHIBITED;
            end else if (ampEnable && isAmpOut) begin
                func = opfc_pkg::FUNC_AMP_OUT;
            end else if (ampEnable && isAmpIn) begin
                func = opfc_pkg::FUNC_AMP_IN;
            end else begin
                func = opfc_pkg::FUNC_ANA_IN;
            end
        end else if (channelHit) begin
            func = opfc_pkg::FUNC_PROHIBITED;
        end else if (ampEnable && isAmpOut) begin
            // A running amplifier output may not share its pin with digital logic.
            func = opfc_pkg::FUNC_PROHIBITED;
        end else if (inputMode) begin
            func = opfc_pkg::FUNC_DIG_IN;
        end else begin
            func = opfc_pkg::FUNC_DIG_OUT;
        end
    end

    // Conversion needs an analog pin in input mode that the channel field names.
    always_comb begin
        convert = analogSel && inputMode && channelHit;
    end

endmodule : opfc_pin_decode

`default_nettype wire

/* sim/opamp_pin_function_config_test.sv */
// Self-checking bench for the pin function block, driven over its Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "opfc_cfg.svh"

module opamp_pin_function_config_test;
    logic sys_clk = 1'b0; // System clock, 200 MHz.
    logic rst_n = 1'b0; // Synchronous reset, active low.
    logic clkEn = 1'b1; // Clock enable, high except for one five-edge freeze near the end.
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [17:0] wb_adr_i = 18'h00000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] portLatch = 8'h5A; // Latch pattern that must never leak onto analog pins.
    logic [7:0] pinIn = 8'h3C; // Pad levels; changed once, late, to show the clock enable freeze.
    logic [7:0] pinOut, pinOe, digitalIn, analogConnect, ampConnect, convertSelect;
    logic amp0Enable, amp1Enable;
    int badCount = 0; // Mismatches seen.
    int compares = 0; // Comparisons made.
    logic [7:0] rd; // Last read data.
    int waits; // Edges from request to sampled acknowledge.

    // Half period of 2.5 ns gives the 5 ns clock.
    always #2.5 sys_clk = ~sys_clk;

    opfc_top #(.ADR_W(18)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .portLatch(portLatch), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .digitalIn(digitalIn), .analogConnect(analogConnect), .ampConnect(ampConnect),
        .convertSelect(convertSelect), .amp0Enable(amp0Enable), .amp1Enable(amp1Enable));

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One classic cycle; the request is held until ack is sampled high.
    // The master sets no limit of its own: only the watchdog ends a hang.
    task automatic busOp(input logic we, input logic [15:0] idx, input logic [7:0] wdata);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, wdata};
        waits = 0;
        do begin
            @(posedge sys_clk);
            waits++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : busOp

    // Reads a register and compares its contents.
    task automatic readCheck(input string what, input logic [15:0] idx, input logic [7:0] exp);
        busOp(1'b0, idx, 8'h00);
        check(what, {24'h0, rd}, {24'h0, exp});
    endtask : readCheck

    // Writes a register, then waits three edges so the pin outputs can follow.
    task automatic wr(input logic [15:0] idx, input logic [7:0] data);
        busOp(1'b1, idx, data);
        repeat (3) @(posedge sys_clk);
    endtask : wr

    // Checks the pin role outputs as one group.
    task automatic pins(input logic [7:0] ana, input logic [7:0] amp, input logic [7:0] oe,
                        input logic [7:0] outv);
        check("analogConnect", {24'h0, analogConnect}, {24'h0, ana});
        check("ampConnect", {24'h0, ampConnect}, {24'h0, amp});
        check("pinOe", {24'h0, pinOe}, {24'h0, oe});
        check("pinOut", {24'h0, pinOut}, {24'h0, outv});
    endtask : pins

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        summarize();
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        check("digitalIn", {24'h0, digitalIn}, 32'h3C);
        readCheck("amp reset", `OPFC_IDX_AMP, 8'h00);
        readCheck("dir reset", `OPFC_IDX_DIR, 8'hFF);
        readCheck("chan reset", `OPFC_IDX_CHAN, 8'h00);
        readCheck("sel reset", `OPFC_IDX_ANA, 8'h00);
        wr(16'h0100, 8'hFF);
        readCheck("unmapped", 16'h0100, 8'h00);
        // Whole-byte write; only the two enable bits may stick.
        wr(`OPFC_IDX_AMP, 8'hFF);
        check("amp write wait", waits, 2);
        readCheck("amp bits", `OPFC_IDX_AMP, 8'h88);
        check("amp0Enable", {31'h0, amp0Enable}, 32'h1);
        check("amp1Enable", {31'h0, amp1Enable}, 32'h1);
        // The selector write must take one extra bus cycle; all pins stay in input mode.
        wr(`OPFC_IDX_ANA, 8'hFF);
        check("sel write wait", waits, 2 + `OPFC_SEL_WAIT);
        readCheck("sel bits", `OPFC_IDX_ANA, 8'hFF);
        pins(8'hFF, 8'hE7, 8'h00, 8'h00);
        // Every channel code; codes 3 and 4 name no pin on this variant.
        for (int c = 0; c < 8; c++) begin
            wr(`OPFC_IDX_CHAN, 8'(c));
            check("convertSelect", {24'h0, convertSelect}, {24'h0, 8'h01 << c & 8'hE7});
            readCheck("chan bits", `OPFC_IDX_CHAN, 8'(c));
        end
        // Amplifier 0 stopped, amplifier 1 running.
        wr(`OPFC_IDX_AMP, 8'h08);
        check("amp0Enable off", {31'h0, amp0Enable}, 32'h0);
        pins(8'hFF, 8'hE0, 8'h00, 8'h00);
        wr(`OPFC_IDX_AMP, 8'h00);
        pins(8'hFF, 8'h00, 8'h00, 8'h00);
        // Analog selection with output mode is left idle, never driven.
        wr(`OPFC_IDX_AMP, 8'h88);
        wr(`OPFC_IDX_DIR, 8'h00);
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        // Every pin reports the prohibited code; channel 7 is a valid code.
        busOp(1'b0, `OPFC_IDX_STAT, 8'h00);
        check("status prohibited", wb_dat_o, 32'h01B6DB6D);
        // Plain digital operation; code 3 names no pin, so no digital pin is named.
        wr(`OPFC_IDX_AMP, 8'h00);
        wr(`OPFC_IDX_CHAN, 8'h03);
        wr(`OPFC_IDX_ANA, 8'h00);
        pins(8'h00, 8'h00, 8'hFF, 8'h5A);
        wr(`OPFC_IDX_DIR, 8'hF0);
        pins(8'h00, 8'h00, 8'h0F, 8'h0A);
        check("digitalIn", {24'h0, digitalIn}, 32'h30);
        readCheck("dir bits", `OPFC_IDX_DIR, 8'hF0);
        // Pins 0 to 3 digital outputs, 4 to 7 digital inputs, channel code invalid.
        busOp(1'b0, `OPFC_IDX_STAT, 8'h00);
        check("status digital", wb_dat_o, 32'h00000249);
        // A low clock enable freezes the synchroniser and the pin outputs.
        clkEn <= 1'b0;
        pinIn <= 8'hC3;
        repeat (5) @(posedge sys_clk);
        check("digitalIn frozen", {24'h0, digitalIn}, 32'h30);
        clkEn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check("digitalIn resumed", {24'h0, digitalIn}, 32'hC0);
        summarize();
    end
endmodule : opamp_pin_function_config_test

`default_nettype wire
